//--- verilog/srpsc_host.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module srpsc_host (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // software port
  input wire logic [7:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o,
  // phy readiness and wake event from the system
  input wire logic phy_ready_i,
  input wire logic power_wake_i,
  // interrupt
  output logic irq_o,
  // device side
  srpsc_if.host dev
);
  typedef struct packed {
    srpsc_pkg::srpsc_host_e seq;
    logic first_read_done;
    logic want_reset;
    logic want_ext;
    logic busy;
    logic refused;
    logic [31:0] hardware_configuration;
    logic [srpsc_pkg::IRQ_W-1:0] irq_st;
    logic [srpsc_pkg::IRQ_W-1:0] irq_en;
    logic wr;
    logic rd;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } srpsc_host_s;

  srpsc_host_s st_r;
  srpsc_host_s st_nxt;
  logic [srpsc_pkg::IRQ_W-1:0] ev;

  always_comb
  begin
    st_nxt = st_r;
    ev = '0;
    st_nxt.wr = 1'b0;
    st_nxt.rd = 1'b0;
    unique case (st_r.seq)
      srpsc_pkg::SRPSC_H_IDLE:
      begin
        if (!st_r.first_read_done || st_r.busy)
        begin
          st_nxt.rd = 1'b1;
          st_nxt.seq = srpsc_pkg::SRPSC_H_RD;
        end
        else if (st_r.want_reset && !phy_ready_i)
        begin
          st_nxt.refused = 1'b1;
          st_nxt.want_reset = 1'b0;
        end
        else if (st_r.want_reset || st_r.want_ext != st_r.hardware_configuration[srpsc_pkg::EXTERNAL_PHY_ENABLE_BIT])
        begin
          st_nxt.wr = 1'b1;
          st_nxt.wdata = '0;
          st_nxt.wdata[srpsc_pkg::EXTERNAL_PHY_ENABLE_BIT] = st_r.want_ext;
          st_nxt.wdata[srpsc_pkg::SOFT_RESET_BIT] = st_r.want_reset;
          st_nxt.busy = st_r.want_reset;
          st_nxt.want_reset = 1'b0;
          st_nxt.seq = srpsc_pkg::SRPSC_H_WR;
        end
      end
      srpsc_pkg::SRPSC_H_RD:
      begin
        st_nxt.seq = srpsc_pkg::SRPSC_H_CHK;
      end
      srpsc_pkg::SRPSC_H_CHK:
      begin
        st_nxt.hardware_configuration = dev.rdata;
        st_nxt.first_read_done = 1'b1;
        st_nxt.seq = srpsc_pkg::SRPSC_H_IDLE;
        if (st_r.busy && !dev.rdata[srpsc_pkg::SOFT_RESET_BIT])
        begin
          st_nxt.busy = 1'b0;
          // device rearms after a reset: one read before next write
          st_nxt.first_read_done = 1'b0;
          if (dev.rdata[srpsc_pkg::RESET_TIMEOUT_BIT])
          begin
            ev[srpsc_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
          end
          else
          begin
            ev[srpsc_pkg::IRQ_DONE_BIT] = 1'b1;
          end
        end
        if (!st_r.first_read_done && dev.rdata[srpsc_pkg::STRAP_BIT])
        begin
          ev[srpsc_pkg::IRQ_STRAP_BIT] = 1'b1;
        end
      end
      srpsc_pkg::SRPSC_H_WR:
      begin
        st_nxt.hardware_configuration[srpsc_pkg::EXTERNAL_PHY_ENABLE_BIT] = st_r.wdata[srpsc_pkg::EXTERNAL_PHY_ENABLE_BIT];
        st_nxt.seq = srpsc_pkg::SRPSC_H_IDLE;
      end
      default:
      begin
        st_nxt.seq = srpsc_pkg::SRPSC_H_IDLE;
      end
    endcase
    // a wake on the edge that returns read data wins, so host and device agree on the gate
    if (power_wake_i)
    begin
      st_nxt.first_read_done = 1'b0;
    end
    st_nxt.rdata = '0;
    if (sw_wr_i)
    begin
      unique case (sw_addr_i)
        srpsc_pkg::CTRL_OFF:
        begin
          // a new request while one is pending is absorbed into it
          st_nxt.want_ext = sw_wdata_i[srpsc_pkg::CTRL_EXT_BIT];
          if (sw_wdata_i[srpsc_pkg::CTRL_GO_BIT])
          begin
            st_nxt.want_reset = 1'b1;
            st_nxt.refused = 1'b0;
          end
        end
        srpsc_pkg::IRQ_CLEAR_OFF:
        begin
          st_nxt.irq_st = st_r.irq_st & ~sw_wdata_i[srpsc_pkg::IRQ_W-1:0];
        end
        srpsc_pkg::IRQ_ENABLE_OFF:
        begin
          st_nxt.irq_en = sw_wdata_i[srpsc_pkg::IRQ_W-1:0];
        end
        default:
        begin
        end
      endcase
    end
    // set wins over clear
    st_nxt.irq_st = st_nxt.irq_st | ev;
    if (sw_rd_i)
    begin
      unique case (sw_addr_i)
        srpsc_pkg::CTRL_OFF:
        begin
          st_nxt.rdata[srpsc_pkg::CTRL_EXT_BIT] = st_r.want_ext;
          st_nxt.rdata[srpsc_pkg::CTRL_GO_BIT] = st_r.want_reset;
        end
        srpsc_pkg::STATUS_OFF:
        begin
          st_nxt.rdata[srpsc_pkg::STATUS_BUSY_BIT] = st_r.busy;
          st_nxt.rdata[srpsc_pkg::STATUS_REFUSED_BIT] = st_r.refused;
          st_nxt.rdata[srpsc_pkg::STATUS_READ_BIT] = st_r.first_read_done;
        end
        srpsc_pkg::IRQ_STATUS_OFF:
        begin
          st_nxt.rdata[srpsc_pkg::IRQ_W-1:0] = st_r.irq_st;
        end
        srpsc_pkg::IRQ_ENABLE_OFF:
        begin
          st_nxt.rdata[srpsc_pkg::IRQ_W-1:0] = st_r.irq_en;
        end
        srpsc_pkg::HWCFG_OFF:
        begin
          st_nxt.rdata = st_r.hardware_configuration;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign dev.wr = st_r.wr;
  assign dev.rd = st_r.rd;
  assign dev.wdata = st_r.wdata;
  assign sw_rdata_o = st_r.rdata;
  assign irq_o = |(st_r.irq_st & st_r.irq_en);
endmodule

//--- verilog/srpsc_pkg.sv
package srpsc_pkg;
  // hardware_configuration bit positions
  localparam int unsigned SOFT_RESET_BIT = 0;
  localparam int unsigned RESET_TIMEOUT_BIT = 1;
  localparam int unsigned EXTERNAL_PHY_ENABLE_BIT = 2;
  localparam int unsigned STRAP_BIT = 3;
  localparam logic [31:0] HARDWARE_CONFIGURATION_RESET = 32'h0000_0000;

  // controller register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_OFF = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_OFF = 8'h10;
  localparam logic [7:0] HWCFG_OFF = 8'h14;

  // ctrl register bits
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_EXT_BIT = 1;
  localparam int unsigned CTRL_RD_BIT = 2;
  // status register bits
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_REFUSED_BIT = 1;
  localparam int unsigned STATUS_READ_BIT = 2;

  // interrupt layout
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_TIMEOUT_BIT = 1;
  localparam int unsigned IRQ_STRAP_BIT = 2;

  // reset wait for phy clocks
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PHY_CLK_WAIT_NS = 2000;
  localparam int unsigned PHY_CLK_WAIT_CYC = (PHY_CLK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 12;
  // cycles the soft reset pulse is held on the mac
  localparam logic [CNT_W-1:0] RESET_PULSE_CYC = 12'h004;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  // phy clocks seen running after this many toggles since reset; gaps between toggles do not restart the count
  localparam logic [2:0] CLK_SEEN_N = 3'h4;

  typedef enum logic [1:0] {
    SRPSC_IDLE = 2'b00,
    SRPSC_WAIT = 2'b01,
    SRPSC_PULSE = 2'b11
  } srpsc_seq_e;

  typedef enum logic [1:0] {
    SRPSC_H_IDLE = 2'b00,
    SRPSC_H_RD = 2'b01,
    SRPSC_H_WR = 2'b11,
    SRPSC_H_CHK = 2'b10
  } srpsc_host_e;
endpackage

//--- verilog/srpsc_if.sv
`timescale 1ns/1ps
interface srpsc_if;
  logic wr;
  logic rd;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport device (
    input wr,
    input rd,
    input wdata,
    output rdata
  );
  modport host (
    output wr,
    output rd,
    output wdata,
    input rdata
  );
endinterface

//--- verilog/srpsc_device.sv
`timescale 1ns/1ps
// Operation
// - capture mdio strap at reset into bit 3
// - strap reads one if mdio high
// - strap value drives no internal logic
// - bit 2 set enables external mii
// - bit 2 clear selects internal phy
// - bit 2 leaves smi and clocks alone
// - reset without phy clocks sets timeout
// - host fixes clocks, then retries reset
// - bit 0 write starts full mac reset
// - system regs reset, survivors keep values
// - soft reset clears tx/rx errors
// - soft_reset clears itself when done
// - host resets only with phy awake
// - host waits for phy after wakeup
// - writes ignored until first read
module srpsc_device (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic power_wake_i,
  // register port
  srpsc_if.device bus,
  // strap pin and phy clocks
  input wire logic mdio_i,
  input wire logic phy_rx_clk_i,
  input wire logic phy_tx_clk_i,
  // error events from the mac
  input wire logic tx_error_set_i,
  input wire logic rx_error_set_i,
  // outputs
  output logic ext_mii_enable_o,
  output logic internal_phy_enable_o,
  output logic mac_soft_reset_o,
  output logic system_command_status_regs_soft_reset_o,
  output logic transmit_error_o,
  output logic receive_error_o
);
  typedef struct packed {
    srpsc_pkg::srpsc_seq_e seq;
    logic [srpsc_pkg::CNT_W-1:0] cnt;
    logic soft_reset;
    logic reset_timeout;
    logic external_phy_enable;
    logic strap;
    logic strap_taken;
    logic armed;
    logic [1:0] rx_sync;
    logic [1:0] tx_sync;
    logic [1:0] md_sync;
    logic rx_last;
    logic tx_last;
    logic [2:0] rx_seen;
    logic [2:0] tx_seen;
    logic tx_err;
    logic rx_err;
    logic [31:0] rdata;
  } srpsc_dev_s;

  srpsc_dev_s st_r;
  srpsc_dev_s st_nxt;

  function automatic logic [2:0] seen_step(input logic [2:0] c, input logic edge_v);
    seen_step = c;
    if (edge_v && c != srpsc_pkg::CLK_SEEN_N)
    begin
      seen_step = c + 3'h1;
    end
  endfunction

  // one tick of the counter shared by strap capture and the reset sequencer
  function automatic logic [srpsc_pkg::CNT_W-1:0] cnt_step(input logic [srpsc_pkg::CNT_W-1:0] c);
    cnt_step = c + srpsc_pkg::CNT_ONE;
  endfunction

  // read image of hardware_configuration; the unused upper bits read as zero
  function automatic logic [31:0] cfg_image(input srpsc_dev_s s);
    cfg_image = 32'h0000_0000;
    cfg_image[srpsc_pkg::SOFT_RESET_BIT] = s.soft_reset;
    cfg_image[srpsc_pkg::RESET_TIMEOUT_BIT] = s.reset_timeout;
    cfg_image[srpsc_pkg::EXTERNAL_PHY_ENABLE_BIT] = s.external_phy_enable;
    cfg_image[srpsc_pkg::STRAP_BIT] = s.strap;
  endfunction

  // detection never decays: clocks that stop after a good reset still count as running
  logic clocks_ok;
  assign clocks_ok = (st_r.rx_seen == srpsc_pkg::CLK_SEEN_N) && (st_r.tx_seen == srpsc_pkg::CLK_SEEN_N);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rx_sync = {st_r.rx_sync[0], phy_rx_clk_i};
    st_nxt.tx_sync = {st_r.tx_sync[0], phy_tx_clk_i};
    st_nxt.md_sync = {st_r.md_sync[0], mdio_i};
    st_nxt.rx_last = st_r.rx_sync[1];
    st_nxt.tx_last = st_r.tx_sync[1];
    st_nxt.rx_seen = seen_step(st_r.rx_seen, st_r.rx_sync[1] != st_r.rx_last);
    st_nxt.tx_seen = seen_step(st_r.tx_seen, st_r.tx_sync[1] != st_r.tx_last);
    // strap is caught once the synchroniser has filled after reset
    if (!st_r.strap_taken && st_r.cnt == srpsc_pkg::CNT_ONE)
    begin
      st_nxt.strap = st_r.md_sync[1];
      st_nxt.strap_taken = 1'b1;
    end
    if (!st_r.strap_taken)
    begin
      st_nxt.cnt = cnt_step(st_r.cnt);
    end
    st_nxt.rdata = cfg_image(st_r);
    // writes before the first read are dropped, as are writes during a reset
    if (bus.wr && st_r.armed && st_r.seq == srpsc_pkg::SRPSC_IDLE)
    begin
      st_nxt.external_phy_enable = bus.wdata[srpsc_pkg::EXTERNAL_PHY_ENABLE_BIT];
      if (bus.wdata[srpsc_pkg::SOFT_RESET_BIT])
      begin
        st_nxt.soft_reset = 1'b1;
        st_nxt.reset_timeout = 1'b0;
        st_nxt.seq = srpsc_pkg::SRPSC_WAIT;
        st_nxt.cnt = '0;
      end
    end
    unique case (st_r.seq)
      srpsc_pkg::SRPSC_IDLE:
      begin
      end
      srpsc_pkg::SRPSC_WAIT:
      begin
        st_nxt.cnt = cnt_step(st_r.cnt);
        if (clocks_ok)
        begin
          st_nxt.seq = srpsc_pkg::SRPSC_PULSE;
          st_nxt.cnt = '0;
        end
        else if (st_r.cnt == srpsc_pkg::CNT_W'(srpsc_pkg::PHY_CLK_WAIT_CYC - 1))
        begin
          st_nxt.seq = srpsc_pkg::SRPSC_IDLE;
          st_nxt.soft_reset = 1'b0;
          st_nxt.reset_timeout = 1'b1;
        end
      end
      srpsc_pkg::SRPSC_PULSE:
      begin
        st_nxt.cnt = cnt_step(st_r.cnt);
        st_nxt.tx_err = 1'b0;
        st_nxt.rx_err = 1'b0;
        if (st_r.cnt == srpsc_pkg::RESET_PULSE_CYC - srpsc_pkg::CNT_ONE)
        begin
          st_nxt.seq = srpsc_pkg::SRPSC_IDLE;
          st_nxt.soft_reset = 1'b0;
          st_nxt.external_phy_enable = 1'b0;
          st_nxt.armed = 1'b0;
        end
      end
      default:
      begin
        st_nxt.seq = srpsc_pkg::SRPSC_IDLE;
      end
    endcase
    if (st_r.seq == srpsc_pkg::SRPSC_IDLE && st_nxt.seq == srpsc_pkg::SRPSC_IDLE && st_r.strap_taken)
    begin
      st_nxt.cnt = st_r.cnt;
    end
    if (power_wake_i)
    begin
      st_nxt.armed = 1'b0;
    end
    // a read on the closing edge of a reset or a wake still counts as the first read
    if (bus.rd)
    begin
      st_nxt.armed = 1'b1;
    end
    // an error flagged while the reset pulse clears the flags wins, so it is never lost
    if (tx_error_set_i)
    begin
      st_nxt.tx_err = 1'b1;
    end
    if (rx_error_set_i)
    begin
      st_nxt.rx_err = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      st_r <= '0;
      // strap pin is sampled all through reset, so the host's first read already sees it
      st_r.md_sync <= st_nxt.md_sync;
      st_r.strap <= st_r.md_sync[1];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign bus.rdata = st_r.rdata;
  // strap goes nowhere but the read path
  assign ext_mii_enable_o = st_r.external_phy_enable;
  assign internal_phy_enable_o = !st_r.external_phy_enable;
  assign mac_soft_reset_o = (st_r.seq == srpsc_pkg::SRPSC_PULSE);
  // system_command_status_regs block keeps its survives_soft_reset bits; it only sees this pulse
  assign system_command_status_regs_soft_reset_o = (st_r.seq == srpsc_pkg::SRPSC_PULSE);
  assign transmit_error_o = st_r.tx_err;
  assign receive_error_o = st_r.rx_err;
endmodule

//--- test/srpsc_checker.sv
`timescale 1ns/1ps
module srpsc_checker (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // bus between the two ends
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata
);
  localparam int WAIT_LO = 195;
  localparam int WAIT_HI = 205;
  logic [7:0] up_r;
  logic [8:0] busy_r;
  logic seen_rd_r;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  // rdata refreshes every cycle, so these count status as software sees it
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      up_r <= 8'h00;
      busy_r <= 9'h000;
      seen_rd_r <= 1'b0;
    end
    else
    begin
      up_r <= (up_r == 8'hFF) ? up_r : up_r + 8'h01;
      busy_r <= rdata[srpsc_pkg::SOFT_RESET_BIT] ? busy_r + 9'h001 : 9'h000;
      seen_rd_r <= seen_rd_r | rd;
    end
  end
  sequence go_wr;
    wr && wdata[srpsc_pkg::SOFT_RESET_BIT];
  endsequence
  sequence rst_start;
    $rose(rdata[srpsc_pkg::SOFT_RESET_BIT]);
  endsequence
  go_start_a: assert property (go_wr |-> ##2 rdata[srpsc_pkg::SOFT_RESET_BIT])
    else $error("soft reset write did not start a reset");
  soft_clear_a: assert property (rst_start |-> ##[1:210] !rdata[srpsc_pkg::SOFT_RESET_BIT])
    else $error("soft reset bit did not clear itself");
  timeout_flag_a: assert property ($rose(rdata[1]) |-> $fell(rdata[0]))
    else $error("timeout flag set without ending the reset");
  wait_len_a: assert property ($rose(rdata[1]) |-> busy_r >= WAIT_LO && busy_r <= WAIT_HI)
    else $error("phy clock wait had the wrong length");
  strap_hold_a: assert property (up_r > 8'h08 |-> $stable(rdata[srpsc_pkg::STRAP_BIT]))
    else $error("strap bit changed after capture");
  ext_write_a: assert property (wr && !wdata[0] |-> ##2 rdata[2] == $past(wdata[2], 2))
    else $error("external enable did not follow the write");
  ext_clear_a: assert property ($fell(rdata[0]) && !rdata[1] |-> !rdata[2])
    else $error("external enable survived a soft reset");
  read_first_a: assert property (wr |-> seen_rd_r)
    else $error("write before the first read");
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] sw_addr_i = 8'h00;
  logic [31:0] sw_wdata_i = 32'h0;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic phy_ready_i = 1'b1;
  logic power_wake_i = 1'b0;
  logic mdio_i = 1'b1;
  logic phy_clk = 1'b0;
  logic clk_run = 1'b0;
  logic tx_err = 1'b0;
  logic rx_err = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] sw_rdata_o;
  logic irq_o, ext_o, int_o, mac_rst, system_command_status_regs_rst, tx_e, rx_e;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] rs = 32'h93B2;
  int miscompares = 0;
  int comparisons = 0;
  int pulse_n = 0;
  int system_command_status_regs_n = 0;
  int t;
  always #5 core_clk_i = ~core_clk_i;
  srpsc_if bus_if ();
  srpsc_device srpsc_device_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .power_wake_i(power_wake_i), .bus(bus_if),
    .mdio_i(mdio_i), .phy_rx_clk_i(phy_clk), .phy_tx_clk_i(phy_clk),
    .tx_error_set_i(tx_err), .rx_error_set_i(rx_err), .ext_mii_enable_o(ext_o),
    .internal_phy_enable_o(int_o), .mac_soft_reset_o(mac_rst), .system_command_status_regs_soft_reset_o(system_command_status_regs_rst),
    .transmit_error_o(tx_e), .receive_error_o(rx_e));
  srpsc_host srpsc_host_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
    .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .phy_ready_i(phy_ready_i),
    .power_wake_i(power_wake_i), .irq_o(irq_o), .dev(bus_if));
  srpsc_checker srpsc_checker_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .wr(bus_if.wr), .rd(bus_if.rd),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // idle edge after each strobe keeps a driver from assigning twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    cyc(1);
    sw_wr_i <= 1'b0;
    cyc(1);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    cyc(1);
    sw_rd_i <= 1'b0;
    cyc(1);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq_o !== 1'b1 && n < 600)
    begin
      cyc(1);
      n++;
    end
    if (n >= 600)
      miscompares++;
  endtask
  task automatic boot();
    reset_i <= 1'b1;
    cyc(12);
    reset_i <= 1'b0;
    cyc(6);
    wr_reg(srpsc_pkg::CTRL_OFF, 32'h4);
    cyc(8);
  endtask
  always @(posedge core_clk_i)
  begin
    rd_q <= sw_rd_i;
    if (rd_q)
      chk(sw_rdata_o & msk_q.pop_front(), exp_q.pop_front(), "rdata");
    if (clk_run)
      phy_clk <= ~phy_clk;
    if (mac_rst === 1'b1)
      pulse_n <= pulse_n + 1;
    if (system_command_status_regs_rst === 1'b1)
      system_command_status_regs_n <= system_command_status_regs_n + 1;
  end
  initial
  begin
    cyc(3000);
    miscompares++;
    end_sim();
  end
  initial
  begin
    boot();
    rd_reg(srpsc_pkg::HWCFG_OFF, 32'h8, 32'hF);
    chk(32'({ext_o, int_o}), 32'h1, "phy select");
    rd_reg(8'h40, 32'h0, 32'hFFFFFFFF);
    rs = xs(rs);
    wr_reg(srpsc_pkg::IRQ_ENABLE_OFF, rs);
    rd_reg(srpsc_pkg::IRQ_ENABLE_OFF, rs, 32'h7);
    wr_reg(srpsc_pkg::IRQ_ENABLE_OFF, 32'h3);
    $display("test strap done");
    phy_ready_i <= 1'b0;
    wr_reg(srpsc_pkg::CTRL_OFF, 32'h1);
    cyc(4);
    rd_reg(srpsc_pkg::STATUS_OFF, 32'h6, 32'h6);
    $display("test refuse done");
    // clock detection never forgets, so the timeout case must run first
    phy_ready_i <= 1'b1;
    wr_reg(srpsc_pkg::CTRL_OFF, 32'h1);
    wait_irq(t);
    chk(32'(t + 4 >= srpsc_pkg::PHY_CLK_WAIT_CYC), 32'h1, "wait span");
    cyc(8);
    rd_reg(srpsc_pkg::IRQ_STATUS_OFF, 32'h2, 32'h3);
    rd_reg(srpsc_pkg::HWCFG_OFF, 32'h2, 32'h3);
    wr_reg(srpsc_pkg::IRQ_CLEAR_OFF, 32'h7);
    cyc(1);
    chk(32'(irq_o), 32'h0, "irq");
    $display("test timeout done");
    wr_reg(srpsc_pkg::CTRL_OFF, 32'h2);
    cyc(8);
    chk(32'({ext_o, int_o}), 32'h2, "phy select");
    clk_run <= 1'b1;
    tx_err <= 1'b1;
    rx_err <= 1'b1;
    cyc(1);
    tx_err <= 1'b0;
    rx_err <= 1'b0;
    cyc(4);
    chk(32'({tx_e, rx_e}), 32'h3, "errors");
    wr_reg(srpsc_pkg::CTRL_OFF, 32'h1);
    wait_irq(t);
    cyc(8);
    chk(32'(pulse_n), 32'(srpsc_pkg::RESET_PULSE_CYC), "mac reset");
    chk(32'(system_command_status_regs_n), 32'(srpsc_pkg::RESET_PULSE_CYC), "system_command_status_regs reset");
    chk(32'({tx_e, rx_e, ext_o, int_o}), 32'h1, "errors and select");
    rd_reg(srpsc_pkg::IRQ_STATUS_OFF, 32'h1, 32'h3);
    rd_reg(srpsc_pkg::HWCFG_OFF, 32'h0, 32'h5);
    $display("test soft reset done");
    power_wake_i <= 1'b1;
    cyc(1);
    power_wake_i <= 1'b0;
    wr_reg(srpsc_pkg::CTRL_OFF, 32'h2);
    cyc(10);
    chk(32'({ext_o, int_o}), 32'h2, "phy select");
    mdio_i <= 1'b0;
    boot();
    rd_reg(srpsc_pkg::HWCFG_OFF, 32'h0, 32'hF);
    cyc(2);
    $display("test strap low done");
    end_sim();
  end
endmodule
